// file: core/short_absolute_move_unit.sv
// Execution datapath for the short absolute move instruction
`timescale 1ns/1ps

// Function
// [RQ1] Six-bit short address zero-extends to sixteen bits, lowest 64 words only.
// [RQ2] Whole accumulator source with extension in use saturates into 16-bit destination.
// [RQ3] Single 16-bit accumulator portion as source passes through unsaturated.
// [RQ4] Saturation sets limit flag; flag stays until explicitly cleared.
// [RQ5] Whole accumulator destination: sign-extend bit 15, middle word, zero low word.
// [RQ6] Upper-portion destination writes only that portion, no extension, no clearing.
// [RQ7] Register/memory short move is one word, two cycles.
// [RQ8] Immediate form writes second-word constant to low memory in four cycles.
// [RQ9] Block-growth flag, status bit 7, updates from data moved.
// [RQ10] All other condition code and mode bits stay unchanged.
module short_absolute_move_unit (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Instruction request
  input wire logic start_in,
  input wire logic [1:0] op_in,
  input wire logic [2:0] src_in,
  input wire logic [2:0] dst_in,
  input wire logic [5:0] short_addr_in,
  input wire logic [15:0] imm_word_in,
  input wire logic [15:0] other_data_in,
  // Data memory
  input wire logic [15:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic mem_re_out,
  output logic mem_we_out,
  output logic imm_fetch_out,
  // Register file side
  output logic reg_we_out,
  output logic [15:0] reg_wdata_out,
  input wire logic acc_load_in,
  input wire logic acc_load_second_in,
  input wire logic [35:0] acc_load_data_in,
  output logic [35:0] acc_first_out,
  output logic [35:0] acc_second_out,
  // Status register
  input wire logic status_load_in,
  input wire logic [15:0] status_data_in,
  output logic [15:0] status_out,
  // Sequencing
  output logic busy_out,
  output logic done_out
);
  typedef enum logic {ST_IDLE, ST_RUN} seq_state_type;

  typedef struct packed {
    seq_state_type state;
    logic [2:0] cnt;
    move_unit_pkg::move_op_type op;
    move_unit_pkg::operand_type dst;
    logic [15:0] addr;
    logic [15:0] data;
    logic limited;
    logic [35:0] acc_first;
    logic [35:0] acc_second;
    logic [15:0] status;
    logic mem_re;
    logic mem_we;
    logic fetch;
    logic reg_we;
    logic busy;
    logic done;
  } unit_state_type;

  unit_state_type q;
  unit_state_type d;

  // Extension in use when bits 35..31 are not all equal
  function automatic logic ext_in_use(input logic [35:0] acc);
    ext_in_use = (acc[move_unit_pkg::ACC_EXT_MSB:move_unit_pkg::ACC_UPPER_MSB] != '0)
      && (acc[move_unit_pkg::ACC_EXT_MSB:move_unit_pkg::ACC_UPPER_MSB] != '1);
  endfunction

  // Returns {limited, word} for a whole accumulator source
  function automatic logic [16:0] limit_acc(input logic [35:0] acc);
    if (ext_in_use(acc)) begin
      limit_acc = {1'b1, acc[move_unit_pkg::ACC_EXT_MSB] ? move_unit_pkg::NEG_SAT
                                                         : move_unit_pkg::POS_SAT}; // [RQ2]
    end else begin
      limit_acc = {1'b0, acc[move_unit_pkg::ACC_UPPER_MSB:move_unit_pkg::ACC_UPPER_LSB]};
    end
  endfunction

  function automatic logic [16:0] read_source(input logic [2:0] sel, input logic [35:0] a,
                                              input logic [35:0] b, input logic [15:0] other);
    unique case (move_unit_pkg::operand_type'(sel))
      move_unit_pkg::SEL_ACC_FIRST: read_source = limit_acc(a);
      move_unit_pkg::SEL_ACC_SECOND: read_source = limit_acc(b);
      // Portions bypass the limiter
      move_unit_pkg::SEL_ACCUMULATOR_UPPER_WORD_FIRST:
        read_source = {1'b0, a[move_unit_pkg::ACC_UPPER_MSB:move_unit_pkg::ACC_UPPER_LSB]}; // [RQ3]
      move_unit_pkg::SEL_ACCUMULATOR_UPPER_WORD_SECOND:
        read_source = {1'b0, b[move_unit_pkg::ACC_UPPER_MSB:move_unit_pkg::ACC_UPPER_LSB]}; // [RQ3]
      move_unit_pkg::SEL_LOWER_FIRST:
        read_source = {1'b0, a[move_unit_pkg::ACC_LOWER_MSB:0]}; // [RQ3]
      move_unit_pkg::SEL_LOWER_SECOND:
        read_source = {1'b0, b[move_unit_pkg::ACC_LOWER_MSB:0]}; // [RQ3]
      default: read_source = {1'b0, other};
    endcase
  endfunction

  function automatic logic growth(input logic [15:0] w);
    growth = w[move_unit_pkg::GROWTH_HI] ^ w[move_unit_pkg::GROWTH_LO];
  endfunction

  function automatic logic [35:0] full_acc_word(input logic [15:0] w);
    full_acc_word = {{move_unit_pkg::ACC_EXT_W{w[move_unit_pkg::WORD_MSB]}}, w,
                     move_unit_pkg::LOW_ZERO}; // [RQ5]
  endfunction

  always_comb begin
    logic [2:0] last;
    logic [16:0] src_val;
    logic [15:0] word;
    last = 3'h0;
    src_val = 17'h0_0000;
    word = 16'h0000;
    d = q;
    d.done = 1'b0;
    d.reg_we = 1'b0;
    d.mem_re = 1'b0;
    d.fetch = 1'b0;
    // Explicit status load or reset are the only ways to clear the sticky flags
    if (status_load_in) begin
      d.status = status_data_in;
    end
    if (acc_load_in) begin
      if (acc_load_second_in) begin
        d.acc_second = acc_load_data_in;
      end else begin
        d.acc_first = acc_load_data_in;
      end
    end
    unique case (q.state)
      ST_IDLE: begin
        if (start_in) begin
          d.op = move_unit_pkg::move_op_type'(op_in);
          d.dst = move_unit_pkg::operand_type'(dst_in);
          d.addr = {{(move_unit_pkg::WORD_W - move_unit_pkg::SHORT_W){1'b0}},
                    short_addr_in}; // [RQ1]
          d.cnt = move_unit_pkg::CYC_FIRST;
          d.busy = 1'b1;
          d.state = ST_RUN;
          d.limited = 1'b0;
          d.mem_re = (op_in == move_unit_pkg::OP_MEM_TO_REG);
          d.fetch = (op_in == move_unit_pkg::OP_IMM_TO_MEM); // [RQ8]
          if (op_in == move_unit_pkg::OP_REG_TO_MEM) begin
            // Operands sampled at issue, so a same-cycle load does not race
            src_val = read_source(src_in, q.acc_first, q.acc_second, other_data_in);
            d.limited = src_val[move_unit_pkg::WORD_W];
            d.data = src_val[move_unit_pkg::WORD_MSB:0];
          end
        end
      end
      ST_RUN: begin
        last = (q.op == move_unit_pkg::OP_IMM_TO_MEM) ? move_unit_pkg::CYC_IMM
                                                       : move_unit_pkg::CYC_SHORT; // [RQ7] [RQ8]
        d.cnt = q.cnt + 3'h1;
        if (q.op == move_unit_pkg::OP_IMM_TO_MEM && q.cnt == move_unit_pkg::IMM_WORD_CYC) begin
          d.data = imm_word_in; // [RQ8]
        end
        if (q.op != move_unit_pkg::OP_MEM_TO_REG && q.cnt == last - 3'h1) begin
          d.mem_we = 1'b1;
        end
        if (q.cnt == last) begin
          d.mem_we = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.state = ST_IDLE;
          d.cnt = 3'h0;
          word = q.data;
          if (q.op == move_unit_pkg::OP_MEM_TO_REG) begin
            word = mem_rdata_in;
            d.data = mem_rdata_in;
            unique case (q.dst)
              move_unit_pkg::SEL_ACC_FIRST: d.acc_first = full_acc_word(word); // [RQ5]
              move_unit_pkg::SEL_ACC_SECOND: d.acc_second = full_acc_word(word); // [RQ5]
              move_unit_pkg::SEL_ACCUMULATOR_UPPER_WORD_FIRST:
                d.acc_first[move_unit_pkg::ACC_UPPER_MSB:move_unit_pkg::ACC_UPPER_LSB] = word; // [RQ6]
              move_unit_pkg::SEL_ACCUMULATOR_UPPER_WORD_SECOND:
                d.acc_second[move_unit_pkg::ACC_UPPER_MSB:move_unit_pkg::ACC_UPPER_LSB] = word; // [RQ6]
              move_unit_pkg::SEL_OTHER: d.reg_we = 1'b1;
              // Lower portions are no legal destination; dropped
              default: d.reg_we = 1'b0;
            endcase
          end
          // Sets win over a same-cycle status load; other bits untouched
          if (q.limited) begin
            d.status[move_unit_pkg::LIMIT_BIT] = 1'b1; // [RQ4] [RQ10]
          end
          if (growth(word)) begin
            d.status[move_unit_pkg::GROWTH_BIT] = 1'b1; // [RQ9]
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      q <= '{state: ST_IDLE, cnt: 3'h0, op: move_unit_pkg::OP_MEM_TO_REG,
             dst: move_unit_pkg::SEL_OTHER, addr: 16'h0000, data: 16'h0000,
             limited: 1'b0, acc_first: move_unit_pkg::ACC_RESET,
             acc_second: move_unit_pkg::ACC_RESET, status: move_unit_pkg::STATUS_RESET,
             mem_re: 1'b0, mem_we: 1'b0, fetch: 1'b0, reg_we: 1'b0, busy: 1'b0, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign mem_addr_out = q.addr;
  assign mem_wdata_out = q.data;
  assign mem_re_out = q.mem_re;
  assign mem_we_out = q.mem_we;
  assign imm_fetch_out = q.fetch;
  assign reg_we_out = q.reg_we;
  assign reg_wdata_out = q.data;
  assign acc_first_out = q.acc_first;
  assign acc_second_out = q.acc_second;
  assign status_out = q.status;
  assign busy_out = q.busy;
  assign done_out = q.done;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_read_strobe: assert property ((start_in && !busy_out && op_in == 2'h0) |=> // [RQ7]
    (mem_re_out && busy_out) ##1 (!mem_re_out && busy_out)) else $error("read strobe wrong");
  chk_addr_zero_ext: assert property ((mem_re_out || mem_we_out) |-> // [RQ1]
    mem_addr_out[15:6] == 10'h000) else $error("short address not zero-extended");
  chk_sat_whole_acc: assert property ((start_in && !busy_out && op_in == 2'h1 && // [RQ2]
    src_in == 3'h0 && ext_in_use(acc_first_out)) |=> ##1 (mem_we_out &&
    (mem_wdata_out == 16'h7fff || mem_wdata_out == 16'h8000)))
    else $error("whole accumulator source not saturated");
  chk_portion_no_sat: assert property ((start_in && !busy_out && op_in == 2'h1 && // [RQ3]
    src_in == 3'h2) |=> ##1 (mem_we_out && mem_wdata_out == $past(acc_first_out[31:16], 2)))
    else $error("upper portion source altered");
  chk_limit_sticky: assert property ((status_out[6] && !status_load_in) |=> // [RQ4]
    status_out[6]) else $error("limit flag lost");
  chk_full_acc_dest: assert property ((done_out && q.op == move_unit_pkg::OP_MEM_TO_REG && // [RQ5]
    q.dst == move_unit_pkg::SEL_ACC_FIRST) |-> acc_first_out ==
    {{4{reg_wdata_out[15]}}, reg_wdata_out, 16'h0000}) else $error("accumulator fill wrong");
  chk_upper_dest_only: assert property ((done_out && !$past(acc_load_in) && // [RQ6]
    q.op == move_unit_pkg::OP_MEM_TO_REG &&
    q.dst == move_unit_pkg::SEL_ACCUMULATOR_UPPER_WORD_FIRST) |->
    (acc_first_out[15:0] == $past(acc_first_out[15:0]) &&
    acc_first_out[35:32] == $past(acc_first_out[35:32])))
    else $error("upper portion write disturbed other bits");
  chk_short_timing: assert property ((start_in && !busy_out && op_in != 2'h2) |=> // [RQ7]
    busy_out [*2] ##1 (done_out && !busy_out)) else $error("short move not two cycles");
  chk_imm_timing: assert property ((start_in && !busy_out && op_in == 2'h2) |=> // [RQ8]
    (busy_out && imm_fetch_out) ##1 busy_out [*3] ##1 (done_out &&
    mem_wdata_out == $past(imm_word_in, 3))) else $error("immediate move wrong");
  chk_growth_set: assert property ((q.busy && q.cnt == 3'h2 && // [RQ9]
    q.op == move_unit_pkg::OP_REG_TO_MEM && (q.data[14] ^ q.data[13])) |=> status_out[7])
    else $error("block growth flag not set");
  chk_other_bits_kept: assert property (!status_load_in |=> // [RQ10]
    (status_out[15:8] == $past(status_out[15:8]) && status_out[5:0] == $past(status_out[5:0])))
    else $error("unrelated status bits changed");
endmodule

// file: inc/move_unit_pkg.sv
// Constants and types for the short absolute move datapath
package move_unit_pkg;
  // Widths
  localparam int WORD_W = 16;
  localparam int ACC_W = 36;
  localparam int SHORT_W = 6;
  localparam int STATUS_W = 16;
  localparam int CNT_W = 3;

  // Accumulator field layout
  localparam int ACC_EXT_MSB = 35;
  localparam int ACC_EXT_LSB = 32;
  localparam int ACC_UPPER_MSB = 31;
  localparam int ACC_UPPER_LSB = 16;
  localparam int ACC_LOWER_MSB = 15;
  localparam int ACC_EXT_W = 4;
  localparam int WORD_MSB = 15;

  // Saturation constants and zero low-word fill
  localparam logic [15:0] POS_SAT = 16'h7fff;
  localparam logic [15:0] NEG_SAT = 16'h8000;
  localparam logic [15:0] LOW_ZERO = 16'h0000;

  // Status register layout: mode byte above, condition codes below
  localparam int LIMIT_BIT = 6;
  localparam int GROWTH_BIT = 7;
  localparam int GROWTH_HI = 14;
  localparam int GROWTH_LO = 13;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [35:0] ACC_RESET = 36'h0_0000_0000;

  // Cycle counts of each form
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_IMM = 3'h4;
  localparam logic [2:0] CYC_FIRST = 3'h1;
  localparam logic [2:0] IMM_WORD_CYC = 3'h2;

  typedef enum logic [1:0] {
    OP_MEM_TO_REG,
    OP_REG_TO_MEM,
    OP_IMM_TO_MEM
  } move_op_type;

  typedef enum logic [2:0] {
    SEL_ACC_FIRST,
    SEL_ACC_SECOND,
    SEL_ACCUMULATOR_UPPER_WORD_FIRST,
    SEL_ACCUMULATOR_UPPER_WORD_SECOND,
    SEL_LOWER_FIRST,
    SEL_LOWER_SECOND,
    SEL_OTHER
  } operand_type;
endpackage

// file: verification/short_absolute_move_unit_bench.sv
// Self-checking bench for the short absolute move datapath
`timescale 1ns/1ps
module short_absolute_move_unit_bench;
  typedef struct packed {
    logic [15:0] st;
    logic [35:0] a;
    logic [35:0] b;
  } state_type;
  logic clock_in, rst_n_in, start_in, acc_load_in, acc_load_second_in, status_load_in;
  logic [1:0] op_in;
  logic [2:0] src_in, dst_in;
  logic [5:0] short_addr_in;
  logic [15:0] imm_word_in, other_data_in, mem_rdata_in, status_data_in;
  logic [35:0] acc_load_data_in;
  logic [15:0] mem_addr_out, mem_wdata_out, reg_wdata_out, status_out;
  logic mem_re_out, mem_we_out, imm_fetch_out, reg_we_out, busy_out, done_out;
  logic [35:0] acc_first_out, acc_second_out;
  state_type done_q[$];
  state_type exp_st;
  logic [31:0] mem_q[$];
  logic [31:0] exp_mem;
  logic [15:0] reg_q[$];
  logic [35:0] acc_m [2];
  logic [15:0] st_m;
  logic [63:0] r;
  int miscompares, total_checks, cycles;

  short_absolute_move_unit i_short_absolute_move_unit (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in),
    .src_in(src_in), .dst_in(dst_in), .short_addr_in(short_addr_in),
    .imm_word_in(imm_word_in), .other_data_in(other_data_in), .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_re_out(mem_re_out),
    .mem_we_out(mem_we_out), .imm_fetch_out(imm_fetch_out), .reg_we_out(reg_we_out),
    .reg_wdata_out(reg_wdata_out), .acc_load_in(acc_load_in),
    .acc_load_second_in(acc_load_second_in), .acc_load_data_in(acc_load_data_in),
    .acc_first_out(acc_first_out), .acc_second_out(acc_second_out),
    .status_load_in(status_load_in), .status_data_in(status_data_in),
    .status_out(status_out), .busy_out(busy_out), .done_out(done_out));

  task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_wide(input string what, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic load_acc(input logic which, input logic [35:0] v);
    @(posedge clock_in);
    acc_load_in <= 1'b1;
    acc_load_second_in <= which;
    acc_load_data_in <= v;
    @(posedge clock_in);
    acc_load_in <= 1'b0;
    acc_m[which] = v;
  endtask

  task automatic load_status(input logic [15:0] v);
    @(posedge clock_in);
    status_load_in <= 1'b1;
    status_data_in <= v;
    @(posedge clock_in);
    status_load_in <= 1'b0;
    st_m = v;
  endtask

  // Model the move first, then issue it and time it
  task automatic run_move(input logic [1:0] op, input logic [2:0] sel, input logic [5:0] addr,
                          input logic [15:0] val);
    logic [35:0] a;
    logic [15:0] w;
    int n;
    a = acc_m[sel[0]];
    w = val;
    if (op == 2'h1) begin
      if (sel < 3'h2 && a[35:31] != {5{a[35]}}) begin
        w = a[35] ? 16'h8000 : 16'h7fff;
        st_m[6] = 1'b1;
      end else if (sel < 3'h4) w = a[31:16];
      else if (sel < 3'h6) w = a[15:0];
    end
    if (w[14] ^ w[13]) st_m[7] = 1'b1;
    if (op != 2'h0) mem_q.push_back({10'h000, addr, w});
    else if (sel < 3'h2) acc_m[sel[0]] = {{4{w[15]}}, w, 16'h0000};
    else if (sel < 3'h4) acc_m[sel[0]][31:16] = w;
    else if (sel == 3'h6) reg_q.push_back(w);
    done_q.push_back({st_m, acc_m[0], acc_m[1]});
    @(posedge clock_in);
    start_in <= 1'b1;
    op_in <= op;
    src_in <= sel;
    dst_in <= sel;
    short_addr_in <= addr;
    other_data_in <= val;
    imm_word_in <= val;
    mem_rdata_in <= val;
    @(posedge clock_in);
    start_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
      #1;
    end while (done_out !== 1'b1 && n < 10);
    check_word("cycles", op == 2'h2 ? 16'h0004 : 16'h0002, n[15:0]);
    // Stale operands must not be mistaken for fresh ones; driven on an edge
    @(posedge clock_in);
    mem_rdata_in <= ~val;
    imm_word_in <= ~val;
  endtask

  always @(posedge clock_in) begin
    if (rst_n_in) begin
      if (mem_we_out === 1'b1) begin
        exp_mem = mem_q.size() > 0 ? mem_q.pop_front() : 'x;
        check_word("mem addr", exp_mem[31:16], mem_addr_out);
        check_word("mem data", exp_mem[15:0], mem_wdata_out);
      end
      if (reg_we_out === 1'b1)
        check_word("reg data", reg_q.size() > 0 ? reg_q.pop_front() : 'x, reg_wdata_out);
      if (done_out === 1'b1) begin
        exp_st = done_q.size() > 0 ? done_q.pop_front() : 'x;
        check_word("status", exp_st.st, status_out);
        check_wide("acc first", exp_st.a, acc_first_out);
        check_wide("acc second", exp_st.b, acc_second_out);
      end
    end
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  initial begin
    {rst_n_in, start_in, acc_load_in, acc_load_second_in, status_load_in} = 5'h00;
    {op_in, src_in, dst_in, short_addr_in} = 14'h0000;
    {imm_word_in, other_data_in, mem_rdata_in, status_data_in} = 64'h0;
    acc_load_data_in = 36'h0_0000_0000;
    acc_m[0] = 36'h0_0000_0000;
    acc_m[1] = 36'h0_0000_0000;
    st_m = 16'h0000;
    void'($urandom(32'h58a1));
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    // Every form with every operand code, both saturation signs first
    for (int i = 0; i < 21; i++) begin
      if (i % 7 == 0) begin
        load_acc(1'b0, 36'h8_1234_5678);
        load_acc(1'b1, 36'h0_8000_0000);
      end
      run_move(2'(i / 7), 3'(i % 7), 6'(6'h3f - i), 16'($urandom));
    end
    load_status(16'ha53c);
    for (int i = 0; i < 80; i++) begin
      r = {$urandom, $urandom};
      if (r[40:39] == 2'h0) load_acc(r[38], r[36] ? {{5{r[31]}}, r[30:0]} : r[35:0]);
      if (r[43:41] == 3'h0) load_status(r[63:48]);
      run_move(2'($urandom % 3), 3'($urandom % 7), 6'($urandom), 16'($urandom));
    end
    repeat (4) @(posedge clock_in);
    check_word("pending", 16'h0000, 16'(done_q.size() + mem_q.size() + reg_q.size()));
    give_verdict();
  end
endmodule
